// file: design/cmc_mode_ctrl.sv
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
module cmc_mode_ctrl (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic i_timer_input_three,
  input wire logic i_timer_input_four,
  input wire logic i_internal_trigger_signal,
  input wire logic i_filtered_external_trigger,
  input wire logic i_trigger_event,
  input wire logic i_update_event,
  input wire logic [15:0] i_counter,
  input wire logic [15:0] i_compare3,
  input wire logic [15:0] i_compare4,
  output logic o_ch3_reference_output,
  output logic o_ch4_reference_output,
  output logic o_ch3_capture,
  output logic o_ch4_capture
);

  cmc_chan_if ch3_if ();
  cmc_chan_if ch4_if ();

  cmc_pkg::cmc_bus_state_t wst_q;
  cmc_pkg::cmc_bus_state_t rst_q;
  logic aw_got_q;
  logic w_got_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [15:0] mode_q;
  logic [15:0] mode_d;
  logic [1:0] enable_q;
  logic [1:0] enable_d;
  logic [1:0] pin_s1_q;
  logic [1:0] pin_s2_q;
  logic [1:0] tr_s1_q;
  logic [1:0] tr_s2_q;
  logic [15:0] cmp3_q;
  logic [15:0] cmp4_q;
  logic [15:0] cmp3_act;
  logic [15:0] cmp4_act;
  logic [1:0] ref_q;
  logic [1:0] ref_d;
  logic aw_take;
  logic w_take;
  logic do_write;
  logic ar_take;
  logic wr_mode;
  logic wr_enable;
  logic wr_hit;
  logic rd_hit;
  logic [31:0] rd_mux;
  logic [31:0] wr_merged;
  logic [15:0] mode_raw;
  logic [1:0] status;

  // Bus channel acceptance. Address and data are latched independently.
  assign aw_take = i_awvalid & o_awready;
  assign w_take = i_wvalid & o_wready;
  assign do_write = (wst_q == cmc_pkg::CMC_IDLE) & (aw_got_q | aw_take) & (w_got_q | w_take);
  assign ar_take = i_arvalid & o_arready;
  assign o_awready = (wst_q == cmc_pkg::CMC_IDLE) & ~aw_got_q;
  assign o_wready = (wst_q == cmc_pkg::CMC_IDLE) & ~w_got_q;
  assign o_arready = (rst_q == cmc_pkg::CMC_IDLE);

  // Write decode on the combined address and data.
  logic [7:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;
  assign wa = aw_got_q ? awaddr_q : i_awaddr;
  assign wd = w_got_q ? wdata_q : i_wdata;
  assign ws = w_got_q ? wstrb_q : i_wstrb;
  assign wr_mode = do_write & (wa[7:2] == cmc_pkg::MODE_OFFSET[7:2]);
  assign wr_enable = do_write & (wa[7:2] == cmc_pkg::ENABLE_OFFSET[7:2]);
  assign wr_hit = (wa[7:2] == cmc_pkg::MODE_OFFSET[7:2]) |
                  (wa[7:2] == cmc_pkg::ENABLE_OFFSET[7:2]) |
                  (wa[7:2] == cmc_pkg::STATUS_OFFSET[7:2]);
  assign wr_merged = {ws[3] ? wd[31:24] : 8'h00, ws[2] ? wd[23:16] : 8'h00,
                      ws[1] ? wd[15:8] : {8'h00 | mode_q[15:8]},
                      ws[0] ? wd[7:0] : mode_q[7:0]};

  // Select fields hold their value while the channel is enabled.
  assign mode_raw = wr_merged[15:0];
  assign mode_d = wr_mode ? {mode_raw[15:10],
      enable_q[1] ? mode_q[9:8] : mode_raw[9:8],
      mode_raw[7:2],
      enable_q[0] ? mode_q[1:0] : mode_raw[1:0]} : mode_q;
  assign enable_d = (wr_enable & ws[0]) ? wd[1:0] : enable_q;

  // Read decode.
  assign status = {ch4_if.level, ch3_if.level};
  assign rd_hit = (i_araddr[7:2] == cmc_pkg::MODE_OFFSET[7:2]) |
                  (i_araddr[7:2] == cmc_pkg::ENABLE_OFFSET[7:2]) |
                  (i_araddr[7:2] == cmc_pkg::STATUS_OFFSET[7:2]);
  assign rd_mux = (i_araddr[7:2] == cmc_pkg::MODE_OFFSET[7:2]) ? {16'h0000, mode_q} :
                  (i_araddr[7:2] == cmc_pkg::ENABLE_OFFSET[7:2]) ? {30'h0, enable_q} :
                  (i_araddr[7:2] == cmc_pkg::STATUS_OFFSET[7:2]) ? {28'h0, ref_q, status} :
                  32'h0000_0000;

  // Write side: hold partial handshakes, answer one cycle after both arrive.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      wst_q <= cmc_pkg::CMC_IDLE;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bresp_q <= cmc_pkg::RESP_OKAY;
    end else if (wst_q == cmc_pkg::CMC_IDLE) begin
      if (aw_take) awaddr_q <= i_awaddr;
      if (w_take) begin
        wdata_q <= i_wdata;
        wstrb_q <= i_wstrb;
      end
      if (do_write) begin
        wst_q <= cmc_pkg::CMC_RESP;
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        bresp_q <= wr_hit ? cmc_pkg::RESP_OKAY : cmc_pkg::RESP_SLVERR;
      end else begin
        aw_got_q <= aw_got_q | aw_take;
        w_got_q <= w_got_q | w_take;
      end
    end else if (i_bready) begin
      wst_q <= cmc_pkg::CMC_IDLE;
    end
  end

  // Read side: data registered on the address handshake.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rst_q <= cmc_pkg::CMC_IDLE;
      rdata_q <= '0;
      rresp_q <= cmc_pkg::RESP_OKAY;
    end else if (rst_q == cmc_pkg::CMC_IDLE) begin
      if (ar_take) begin
        rst_q <= cmc_pkg::CMC_RDATA;
        rdata_q <= rd_mux;
        rresp_q <= rd_hit ? cmc_pkg::RESP_OKAY : cmc_pkg::RESP_SLVERR;
      end
    end else if (i_rready) begin
      rst_q <= cmc_pkg::CMC_IDLE;
    end
  end

  assign o_bvalid = (wst_q == cmc_pkg::CMC_RESP);
  assign o_bresp = bresp_q;
  assign o_rvalid = (rst_q == cmc_pkg::CMC_RDATA);
  assign o_rdata = rdata_q;
  assign o_rresp = rresp_q;

  // Configuration registers.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      mode_q <= cmc_pkg::MODE_RESET;
      enable_q <= cmc_pkg::ENABLE_RESET;
    end else begin
      mode_q <= mode_d;
      enable_q <= enable_d;
    end
  end

  // Pins from outside pass two flip-flops before use.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      tr_s1_q <= '0;
      tr_s2_q <= '0;
    end else begin
      pin_s1_q <= {i_timer_input_four, i_timer_input_three};
      pin_s2_q <= pin_s1_q;
      tr_s1_q <= {i_filtered_external_trigger, i_internal_trigger_signal};
      tr_s2_q <= tr_s1_q;
    end
  end

  // Capture channels take their fields from the mode bits whatever the select; an output select holds the prescaler cleared.
  assign ch3_if.sel = mode_q[1:0];
  assign ch3_if.psc = mode_q[cmc_pkg::PSC_LSB +: 2];
  assign ch3_if.filt = mode_q[cmc_pkg::FILT_LSB +: 4];
  assign ch3_if.enable = enable_q[0];
  assign ch3_if.own_in = pin_s2_q[0];
  assign ch3_if.near_in = pin_s2_q[1];
  assign ch3_if.trig_in = tr_s2_q[0];
  assign ch4_if.sel = mode_q[9:8];
  assign ch4_if.psc = mode_q[cmc_pkg::CH4_BASE + cmc_pkg::PSC_LSB +: 2];
  assign ch4_if.filt = mode_q[cmc_pkg::CH4_BASE + cmc_pkg::FILT_LSB +: 4];
  assign ch4_if.enable = enable_q[1];
  assign ch4_if.own_in = pin_s2_q[1];
  assign ch4_if.near_in = pin_s2_q[0];
  assign ch4_if.trig_in = tr_s2_q[0];

  cmc_capture_chan u_ch3 (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .io_ch(ch3_if)
  );

  cmc_capture_chan u_ch4 (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .io_ch(ch4_if)
  );

  // Preloaded compare values only move on an update event.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      cmp3_q <= '0;
      cmp4_q <= '0;
    end else if (i_update_event) begin
      cmp3_q <= i_compare3;
      cmp4_q <= i_compare4;
    end
  end
  assign cmp3_act = mode_q[cmc_pkg::PRELOAD_BIT] ? cmp3_q : i_compare3;
  assign cmp4_act = mode_q[cmc_pkg::CH4_BASE + cmc_pkg::PRELOAD_BIT] ? cmp4_q : i_compare4;

  // Reference waveform for one channel from its mode bits.
  function automatic logic ref_next(input logic [7:0] f, input logic cur,
                                    input logic [15:0] cnt, input logic [15:0] cmp,
                                    input logic trg, input logic etr);
    logic match;
    logic lt;
    logic r;
    match = (cnt == cmp);
    lt = (cnt < cmp);
    r = cur;
    unique case (f[cmc_pkg::MODE_LSB +: 3])
      cmc_pkg::OCM_FROZEN: r = cur;
      cmc_pkg::OCM_SET: r = match ? 1'b1 : cur;
      cmc_pkg::OCM_CLEAR: r = match ? 1'b0 : cur;
      cmc_pkg::OCM_TOGGLE: r = match ? ~cur : cur;
      cmc_pkg::OCM_FORCE_LOW: r = 1'b0;
      cmc_pkg::OCM_FORCE_HIGH: r = 1'b1;
      cmc_pkg::OCM_PWM1: r = lt | (f[cmc_pkg::FAST_BIT] & trg);
      cmc_pkg::OCM_PWM2: r = ~lt & ~(f[cmc_pkg::FAST_BIT] & trg);
    endcase
    if (f[cmc_pkg::CLEAR_BIT] && etr) r = 1'b0;
    if (f[1:0] != cmc_pkg::SEL_OUTPUT) r = 1'b0;
    return r;
  endfunction

  assign ref_d[0] = ref_next(mode_q[7:0], ref_q[0], i_counter, cmp3_act,
                             i_trigger_event, tr_s2_q[1]);
  assign ref_d[1] = ref_next(mode_q[15:8], ref_q[1], i_counter, cmp4_act,
                             i_trigger_event, tr_s2_q[1]);

  // Reference and capture outputs all leave from flip-flops.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ref_q <= '0;
      o_ch3_capture <= 1'b0;
      o_ch4_capture <= 1'b0;
    end else begin
      ref_q <= ref_d;
      o_ch3_capture <= ch3_if.capture;
      o_ch4_capture <= ch4_if.capture;
    end
  end
  assign o_ch3_reference_output = ref_q[0];
  assign o_ch4_reference_output = ref_q[1];

endmodule

// file: design/cmc_pkg.sv
package cmc_pkg;

  // Register map. The mode register sits at its printed byte offset.
  localparam logic [7:0] MODE_OFFSET = 8'h1c;
  localparam logic [7:0] ENABLE_OFFSET = 8'h20;
  localparam logic [7:0] STATUS_OFFSET = 8'h24;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [1:0] ENABLE_RESET = 2'h0;

  // Field positions, channel 3 at base 0 and channel 4 at base 8.
  localparam int CH4_BASE = 8;
  localparam int SEL_LSB = 0;
  localparam int FAST_BIT = 2;
  localparam int PRELOAD_BIT = 3;
  localparam int MODE_LSB = 4;
  localparam int CLEAR_BIT = 7;
  localparam int PSC_LSB = 2;
  localparam int FILT_LSB = 4;

  // Direction select codes.
  localparam logic [1:0] SEL_OUTPUT = 2'h0;
  localparam logic [1:0] SEL_OWN = 2'h1;
  localparam logic [1:0] SEL_NEIGHBOUR = 2'h2;
  localparam logic [1:0] SEL_TRIGGER = 2'h3;

  // Output compare modes.
  localparam logic [2:0] OCM_FROZEN = 3'h0;
  localparam logic [2:0] OCM_SET = 3'h1;
  localparam logic [2:0] OCM_CLEAR = 3'h2;
  localparam logic [2:0] OCM_TOGGLE = 3'h3;
  localparam logic [2:0] OCM_FORCE_LOW = 3'h4;
  localparam logic [2:0] OCM_FORCE_HIGH = 3'h5;
  localparam logic [2:0] OCM_PWM1 = 3'h6;
  localparam logic [2:0] OCM_PWM2 = 3'h7;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Bus slave states.
  typedef enum logic [2:0] {
    CMC_IDLE = 3'b001,
    CMC_RESP = 3'b010,
    CMC_RDATA = 3'b100
  } cmc_bus_state_t;

endpackage

// file: design/cmc_chan_if.sv
`timescale 1ns/1ps
// Per-channel configuration and input handed to a capture channel.
interface cmc_chan_if;
  logic [1:0] sel;
  logic [1:0] psc;
  logic [3:0] filt;
  logic enable;
  logic own_in;
  logic near_in;
  logic trig_in;
  logic capture;
  logic level;

  modport ctrl (output sel, psc, filt, enable, own_in, near_in, trig_in, input capture, level);
  modport chan (input sel, psc, filt, enable, own_in, near_in, trig_in, output capture, level);
endinterface

// file: design/cmc_capture_chan.sv
`timescale 1ns/1ps
// One capture path: source mux, digital filter, edge detect, prescaler.
module cmc_capture_chan (
  input wire logic i_core_clk,
  input wire logic i_rst,
  cmc_chan_if.chan io_ch
);

  logic src;
  logic [4:0] div_lim;
  logic [3:0] n_lim;
  logic [4:0] div_q;
  logic [3:0] cnt_q;
  logic filt_q;
  logic prev_q;
  logic [2:0] psc_q;
  logic cap_q;
  logic tick;
  logic rise;
  logic [2:0] psc_top;

  // Source choice by the direction select field.
  assign src = (io_ch.sel == cmc_pkg::SEL_OWN) ? io_ch.own_in :
               (io_ch.sel == cmc_pkg::SEL_NEIGHBOUR) ? io_ch.near_in : io_ch.trig_in;

  // Filter table, divider minus one and sample count. Code 0 passes every sample.
  always_comb begin
    unique case (io_ch.filt)
      4'h1: begin div_lim = 5'd0; n_lim = 4'd2; end
      4'h2: begin div_lim = 5'd0; n_lim = 4'd4; end
      4'h3: begin div_lim = 5'd0; n_lim = 4'd8; end
      4'h4: begin div_lim = 5'd1; n_lim = 4'd6; end
      4'h5: begin div_lim = 5'd1; n_lim = 4'd8; end
      4'h6: begin div_lim = 5'd3; n_lim = 4'd6; end
      4'h7: begin div_lim = 5'd3; n_lim = 4'd8; end
      4'h8: begin div_lim = 5'd7; n_lim = 4'd6; end
      4'h9: begin div_lim = 5'd7; n_lim = 4'd8; end
      4'ha: begin div_lim = 5'd15; n_lim = 4'd5; end
      4'hb: begin div_lim = 5'd15; n_lim = 4'd6; end
      4'hc: begin div_lim = 5'd15; n_lim = 4'd8; end
      4'hd: begin div_lim = 5'd31; n_lim = 4'd5; end
      4'he: begin div_lim = 5'd31; n_lim = 4'd6; end
      4'hf: begin div_lim = 5'd31; n_lim = 4'd8; end
      default: begin div_lim = 5'd0; n_lim = 4'd1; end
    endcase
  end

  assign tick = (div_q == div_lim);
  assign rise = filt_q & ~prev_q;
  assign psc_top = 3'((1 << io_ch.psc) - 1);

  // Sampling divider runs free.
  always_ff @(posedge i_core_clk) begin
    if (i_rst || tick) div_q <= '0;
    else div_q <= div_q + 5'd1;
  end

  // Accept a change only after N equal samples in a row.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      cnt_q <= '0;
      filt_q <= 1'b0;
    end else if (tick) begin
      if (src == filt_q) cnt_q <= '0;
      else if (cnt_q + 4'd1 >= n_lim) begin
        filt_q <= src;
        cnt_q <= '0;
      end else cnt_q <= cnt_q + 4'd1;
    end
  end

  // Prescaler counts rising edges only while the channel is an enabled input.
  // Disabling the channel rewinds it so the next capture counts from one.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      prev_q <= 1'b0;
      psc_q <= '0;
      cap_q <= 1'b0;
    end else begin
      prev_q <= filt_q;
      cap_q <= 1'b0;
      if (!io_ch.enable || io_ch.sel == cmc_pkg::SEL_OUTPUT) psc_q <= '0;
      else if (rise) begin
        if (psc_q >= psc_top) begin
          psc_q <= '0;
          cap_q <= 1'b1;
        end else psc_q <= psc_q + 3'd1;
      end
    end
  end

  assign io_ch.capture = cap_q;
  assign io_ch.level = filt_q;

endmodule

// file: test/cmc_mode_ctrl_sva.sv
`timescale 1ns/1ps
module cmc_mode_ctrl_sva (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic [1:0] o_bresp,
  input wire logic o_bvalid,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic i_filtered_external_trigger,
  input wire logic o_ch3_reference_output,
  input wire logic o_ch4_reference_output,
  input wire logic o_ch3_capture
);
  logic [15:0] mode_q;
  logic [1:0] en_q;
  logic [7:0] ar_q;
  logic [7:0] lo_b;
  logic [7:0] hi_b;
  logic wr_fire;

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  // Shadow copy of the mode register; select fields hold while their channel is enabled.
  assign wr_fire = i_awvalid & o_awready & i_wvalid & o_wready;
  assign lo_b = i_wstrb[0] ? i_wdata[7:0] : mode_q[7:0];
  assign hi_b = i_wstrb[1] ? i_wdata[15:8] : mode_q[15:8];

  // Shadow registers follow accepted writes and read addresses.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      mode_q <= 16'h0000;
      en_q <= 2'h0;
      ar_q <= 8'h00;
    end else begin
      if (i_arvalid && o_arready) ar_q <= i_araddr;
      if (wr_fire && i_awaddr == 8'h20 && i_wstrb[0]) en_q <= i_wdata[1:0];
      if (wr_fire && i_awaddr == 8'h1c) begin
        mode_q <= {hi_b[7:2], en_q[1] ? mode_q[9:8] : hi_b[1:0],
                   lo_b[7:2], en_q[0] ? mode_q[1:0] : lo_b[1:0]};
      end
    end
  end

  a_write_answer: assert property (wr_fire |=> o_bvalid)
    else $error("write not answered");
  a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read not answered");
  a_mode_readback: assert property (o_rvalid && ar_q == 8'h1c |-> o_rdata == {16'h0, mode_q})
    else $error("mode readback wrong");
  a_enable_readback: assert property (o_rvalid && ar_q == 8'h20 |-> o_rdata == {30'h0, en_q})
    else $error("enable readback wrong");
  a_unmapped_err: assert property (wr_fire && i_awaddr == 8'h30 |=> o_bresp == 2'h2)
    else $error("unmapped write not refused");
  // Two synchroniser stages plus the output register put three edges between pin and output.
  a_clear_ch3: assert property ((mode_q[1:0] == 2'h0 && mode_q[7] &&
    i_filtered_external_trigger)[*4] |-> !o_ch3_reference_output)
    else $error("ch3 reference not cleared");
  a_clear_ch4: assert property ((mode_q[9:8] == 2'h0 && mode_q[15] &&
    i_filtered_external_trigger)[*4] |-> !o_ch4_reference_output)
    else $error("ch4 reference not cleared");
  a_input_quiet: assert property ((mode_q[1:0] != 2'h0)[*2] |-> !o_ch3_reference_output)
    else $error("ch3 reference active as input");
  a_capture_pulse: assert property (o_ch3_capture |=> !o_ch3_capture)
    else $error("capture pulse too long");
endmodule

bind cmc_mode_ctrl cmc_mode_ctrl_sva i_sva (.*);

// file: test/cmc_timer_side.sv
`timescale 1ns/1ps
// Far side: pins pulse a burst of EDGES rising edges, each level held HALF cycles.
module cmc_timer_side #(
  parameter int HALF = 4,
  parameter int EDGES = 8
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [2:0] i_src,
  input wire logic i_start,
  output logic o_timer_input_three,
  output logic o_timer_input_four,
  output logic o_internal_trigger_signal,
  output logic o_trigger_event,
  output logic o_update_event,
  output logic [15:0] o_counter
);
  logic [7:0] half_q;
  logic [2:0] tick_q;
  logic lvl_q;
  logic trc_q;
  logic [15:0] cnt_q;

  // Pins rest low between bursts, so a change of source never fakes an edge.
  assign o_timer_input_three = i_src[0] & lvl_q;
  assign o_timer_input_four = i_src[1] & lvl_q;
  assign o_internal_trigger_signal = i_src[2] & lvl_q;
  assign o_trigger_event = o_internal_trigger_signal & ~trc_q;
  assign o_update_event = (cnt_q[7:0] == 8'hff);
  assign o_counter = cnt_q;

  // Free-running counter plus the burst sequencer.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      half_q <= 8'h00;
      tick_q <= 3'h0;
      lvl_q <= 1'b0;
      trc_q <= 1'b0;
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      trc_q <= o_internal_trigger_signal;
      if (i_start) begin
        half_q <= 8'(2 * EDGES);
        tick_q <= 3'h0;
        lvl_q <= 1'b0;
      end else if (half_q != 8'h00) begin
        tick_q <= tick_q + 3'h1;
        if (tick_q == 3'(HALF - 1)) begin
          tick_q <= 3'h0;
          lvl_q <= ~lvl_q;
          half_q <= half_q - 8'h01;
        end
      end
    end
  end
endmodule

// file: test/channel3_4_mode_config_tb.sv
`timescale 1ns/1ps
module channel3_4_mode_config_tb;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [3:0] s; logic [15:0] e; logic [1:0] r;} cmc_row_t;
  logic clk, rst, awvalid, wvalid, arvalid, bready, rready, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic ti3, ti4, internal_trigger_signal, etr, trg, upd, ref3, ref4, cap3, cap4, go;
  logic [15:0] cnt;
  logic [2:0] src;
  int error_cnt, samples_checked, n3, n4;
  cmc_row_t rows [8] = '{'{8'h1c, 32'h7e7e, 4'hf, 16'h7e7e, 2'h0},
    '{8'h1c, 32'hffff1234, 4'h1, 16'h7e34, 2'h0}, '{8'h1c, 32'hab00, 4'h2, 16'hab34, 2'h0},
    '{8'h20, 32'h3, 4'hf, 16'h3, 2'h0}, '{8'h1c, 32'h0, 4'hf, 16'h0300, 2'h0},
    '{8'h20, 32'h0, 4'hf, 16'h0, 2'h0}, '{8'h1c, 32'h0, 4'hf, 16'h0, 2'h0},
    '{8'h30, 32'h1, 4'hf, 16'h0, 2'h2}};

  cmc_mode_ctrl i_dut (.i_core_clk(clk), .i_rst(rst), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
    .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
    .o_rvalid(rvalid), .i_rready(rready), .i_timer_input_three(ti3), .i_timer_input_four(ti4),
    .i_internal_trigger_signal(internal_trigger_signal), .i_filtered_external_trigger(etr), .i_trigger_event(trg),
    .i_update_event(upd), .i_counter(cnt), .i_compare3(16'h0040), .i_compare4(16'h0080),
    .o_ch3_reference_output(ref3), .o_ch4_reference_output(ref4), .o_ch3_capture(cap3),
    .o_ch4_capture(cap4));
  cmc_timer_side i_side (.i_core_clk(clk), .i_rst(rst), .i_src(src), .i_start(go),
    .o_timer_input_three(ti3), .o_timer_input_four(ti4), .o_internal_trigger_signal(internal_trigger_signal),
    .o_trigger_event(trg), .o_update_event(upd), .o_counter(cnt));

  // Response channels are always ready, so bready and rready are never toggled.
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
    logic done;
    done = 1'b0;
    awaddr <= a; wdata <= v; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        done = 1'b1;
        r = bresp;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a; arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    d = rdata; r = rresp;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One burst of eight edges on the chosen pins; captures are counted once per cycle.
  task automatic burst(input logic [2:0] s);
    src <= s; go <= 1'b1;
    @(posedge clk);
    go <= 1'b0; n3 = 0; n4 = 0;
    repeat (84) begin
      @(posedge clk);
      n3 += int'(cap3); n4 += int'(cap4);
    end
  endtask
  task automatic setmode(input logic [15:0] m, input logic [1:0] en);
    wr(8'h20, 32'h0, 4'hf);
    wr(8'h1c, {16'h0, m}, 4'hf);
    wr(8'h20, {30'h0, en}, 4'hf);
  endtask
  task automatic close_out();
    if (error_cnt == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #100us;
    error_cnt++;
    close_out();
  end
  initial begin
    rst = 1'b1; awvalid = 0; wvalid = 0; arvalid = 0; bready = 1; rready = 1; etr = 0; go = 0;
    awaddr = 0; araddr = 0; wdata = 0; wstrb = 0; src = 0; error_cnt = 0; samples_checked = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(8'h1c); chk(d, 32'h0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, rows[i].s); chk({30'h0, r}, {30'h0, rows[i].r});
      rd(rows[i].a); chk({30'h0, r}, {30'h0, rows[i].r});
      if (rows[i].r == 2'h0) chk(d, {16'h0, rows[i].e});
    end
    // Every source code on both channels against every pin.
    for (int s = 1; s < 4; s++) begin
      setmode({6'h0, s[1:0], 6'h0, s[1:0]}, 2'h3);
      for (int k = 0; k < 3; k++) begin
        burst(3'b001 << k);
        chk(32'(n3), (k == s - 1) ? 32'h8 : 32'h0);
        chk(32'(n4), (k == ((s == 3) ? 2 : 2 - s)) ? 32'h8 : 32'h0);
      end
    end
    for (int p = 0; p < 4; p++) begin
      setmode({12'h0, p[1:0], 2'h1}, 2'h1);
      burst(3'b001); chk(32'(n3), 32'h8 >> p);
    end
    // A long filter swallows four-cycle pulses; ch4 divides by four.
    setmode(16'h0931, 2'h3);
    burst(3'b011); chk(32'(n3), 32'h0); chk(32'(n4), 32'h2);
    setmode(16'h50d0, 2'h3);
    repeat (4) @(posedge clk);
    rd(8'h24); chk(d & 32'hc, 32'hc);
    etr <= 1'b1;
    repeat (4) @(posedge clk);
    rd(8'h24); chk(d & 32'hc, 32'h8);
    setmode(16'hd050, 2'h3);
    repeat (4) @(posedge clk);
    rd(8'h24); chk(d & 32'hc, 32'h4);
    etr <= 1'b0;
    setmode(16'h5051, 2'h3);
    repeat (4) @(posedge clk);
    rd(8'h24); chk(d & 32'hc, 32'h8);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(8'h1c); chk(d, 32'h0);
    rd(8'h20); chk(d, 32'h0);
    close_out();
  end
endmodule
